// File: testbench/connection_queue_flow_ctrl_bench.sv
// Self-checking bench for the connection queue block
`timescale 1ns/100ps
`include "cqf_defs.svh"
module connection_queue_flow_ctrl_bench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, dn, pz, jz;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] xfer_req, xfer_done, xfer_refused;
	logic sdram_req, sdram_we, sdram_ack, fs, fd, fce, pause, jam;
	logic htx, stx, srx, hrx, hclk, irq;
	logic [`CQF_SLOT_W-1:0] slot, sl;
	int fails = 0, checked = 0, cyc = 0, i, n;

	cqf_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .xfer_req(xfer_req), .xfer_done(xfer_done),
		.xfer_refused(xfer_refused), .sdram_req(sdram_req), .sdram_we(sdram_we),
		.sdram_slot(slot), .sdram_ack(sdram_ack), .mac_rx_frame_start(fs),
		.mac_rx_frame_done(fd), .mac_flow_ctrl_enable(fce), .mac_pause_send(pause),
		.mac_jam_frame(jam), .hdlc_tx_data(htx), .serial_tx_data(stx),
		.serial_rx_pin(srx), .hdlc_rx_data(hrx), .hdlc_clk_enable(hclk), .queue_irq(irq));
	cqf_sdram_model sdram_u (.pclk(pclk), .presetn(presetn), .sdram_req(sdram_req),
		.sdram_ack(sdram_ack));

	// Clock and hang guard
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			results();
		end
	end

	// ----------------------------------------
	// Tasks and expectation helpers
	// ----------------------------------------
	task results;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	function logic [31:0] stat(input logic h, input logic l, input logic o);
		return {29'h0, o, l, h};
	endfunction
	function logic [31:0] occw(input logic [13:0] t, input logic [13:0] r);
		return {2'h0, r, 2'h0, t};
	endfunction
	// APB cycle; read data and error taken at the pready edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Level request held until done or refused, for at most 40 cycles
	task xfer(input int k);
		@(posedge pclk);
		xfer_req[k] <= 1'b1;
		for (int t = 0; t < 40; t++) begin
			@(posedge pclk);
			htx <= 1'($urandom);
			srx <= 1'($urandom);
			if (xfer_done[k] === 1'b1 || xfer_refused[k] === 1'b1) break;
		end
		dn = xfer_done[k];
		sl = slot;
		xfer_req[k] <= 1'b0;
	endtask
	// Frame pulse; registered answer sampled one cycle on
	task frame(input logic s);
		@(posedge pclk);
		fs <= s;
		fd <= !s;
		@(posedge pclk);
		fs <= 1'b0;
		fd <= 1'b0;
		@(posedge pclk);
		pz = pause;
		jz = jam;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{presetn, psel, penable, pwrite, fs, fd, htx, err} = 8'h0;
		{paddr, pwdata, xfer_req} = 48'h0;
		srx = 1'b1;
		void'($urandom(32'h230c));
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		chk("fce", 32'h1, 32'(fce));
		chk("tx_idle", 32'h1, 32'(stx));
		chk("clk_off", 32'h0, 32'(hclk));
		apb(1'b0, `CQF_CTRL_OFS, 32'h0);
		chk("ctrl", 32'h4, rd);
		apb(1'b0, `CQF_RXQ_SIZE_OFS, 32'h0);
		chk("rxq", 32'h1, rd);
		apb(1'b0, 12'h100, 32'h0);
		chk("unmapped", 32'h1, {31'h0, err});
		$display("reset test done");
		apb(1'b1, `CQF_TXQ_SIZE_OFS, 32'h1);
		apb(1'b1, `CQF_RXQ_SIZE_OFS, 32'h2);
		apb(1'b1, `CQF_RX_THR_OFS, 32'h0001_0001);
		apb(1'b1, `CQF_RX_IE_OFS, 32'h1);
		apb(1'b1, `CQF_GLB_IE_OFS, 32'h2);
		apb(1'b1, `CQF_CTRL_OFS, 32'h6);
		apb(1'b1, `CQF_CTRL_OFS, 32'h45);
		xfer(2);
		chk("tx_wr", 32'h1, 32'(dn));
		chk("tx_slot", 32'h40, 32'(sl));
		apb(1'b0, `CQF_TX_STAT_OFS, 32'h0);
		chk("tx_st", stat(1'b1, 1'b1, 1'b0), rd);
		apb(1'b0, `CQF_TX_STAT_OFS, 32'h0);
		chk("tx_clr", 32'h0, rd);
		xfer(3);
		chk("tx_rd", 32'h40, 32'(sl));
		apb(1'b0, `CQF_TX_STAT_OFS, 32'h0);
		chk("tx_low", stat(1'b0, 1'b1, 1'b0), rd);
		$display("tx test done");
		for (i = 0; i < 64; i++) begin
			xfer(0);
			chk("rx_slot", 32'(i), dn ? 32'(sl) : 32'hffff);
		end
		chk("irq", 32'h1, 32'(irq));
		apb(1'b0, `CQF_OCC_OFS, 32'h0);
		chk("occ", occw(14'h0, 14'h40), rd);
		apb(1'b0, `CQF_RX_STAT_OFS, 32'h0);
		chk("rx_st", stat(1'b1, 1'b1, 1'b0), rd);
		// The clear lands at the access edge; look one edge later
		@(posedge pclk);
		chk("irq_clr", 32'h0, 32'(irq));
		xfer(0);
		chk("ovf_ref", 32'h0, 32'(dn));
		apb(1'b0, `CQF_RX_STAT_OFS, 32'h0);
		chk("ovf", stat(1'b0, 1'b0, 1'b1), rd);
		$display("rx fill test done");
		frame(1'b0);
		chk("pause", 32'h2, {pz, jz});
		apb(1'b1, `CQF_CTRL_OFS, 32'h5);
		frame(1'b1);
		chk("jam", 32'h1, {pz, jz});
		repeat (33) xfer(1);
		frame(1'b1);
		chk("jam_off", 32'h0, {pz, jz});
		chk("fce_auto", 32'h1, 32'(fce));
		$display("auto flow test done");
		apb(1'b1, `CQF_CTRL_OFS, 32'h1);
		repeat (2) @(posedge pclk);
		chk("fce_man0", 32'h0, 32'(fce));
		apb(1'b1, `CQF_CTRL_OFS, 32'h11);
		repeat (2) @(posedge pclk);
		chk("fce_man1", 32'h1, 32'(fce));
		apb(1'b1, `CQF_CTRL_OFS, 32'h9);
		frame(1'b1);
		chk("jam_man", 32'h1, 32'(jz));
		apb(1'b1, `CQF_CTRL_OFS, 32'h61);
		n = 0;
		repeat (4) begin
			@(posedge pclk);
			n += int'(pause);
		end
		chk("pause_man", 32'h1, 32'(n));
		$display("manual flow test done");
		apb(1'b1, `CQF_CTRL_OFS, 32'h3);
		apb(1'b0, `CQF_OCC_OFS, 32'h0);
		chk("ptr_rst", 32'h0, rd);
		apb(1'b1, `CQF_CTRL_OFS, 32'h0);
		repeat (3) @(posedge pclk);
		chk("disc", 32'h3, {hclk, stx, hrx});
		xfer(0);
		chk("disc_ref", 32'h0, 32'(dn));
		$display("teardown test done");
		results();
	end
endmodule

// File: testbench/cqf_sdram_model.sv
// SDRAM side model answering arbiter accesses after a random wait
`timescale 1ns/100ps
module cqf_sdram_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic sdram_req,
	output logic sdram_ack
);
	logic [1:0] wait_q;
	// one access answered at a time
	// Random wait so both prompt and slow answers occur
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sdram_ack <= 1'b0;
			wait_q <= 2'h0;
		end else if (sdram_ack) begin
			sdram_ack <= 1'b0;
		end else if (sdram_req && wait_q == 2'h0) begin
			sdram_ack <= 1'b1;
			wait_q <= 2'($urandom_range(3, 0));
		end else if (sdram_req) begin
			wait_q <= wait_q - 2'h1;
		end
	end
endmodule

// File: testbench/cqf_top_assertions.sv
// Port timing checker for the connection queue block
`timescale 1ns/100ps
`include "cqf_defs.svh"
module cqf_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [3:0] xfer_done,
	input wire logic [3:0] xfer_refused,
	input wire logic sdram_req,
	input wire logic sdram_we,
	input wire logic [`CQF_SLOT_W-1:0] sdram_slot,
	input wire logic sdram_ack,
	input wire logic mac_rx_frame_start,
	input wire logic mac_pause_send,
	input wire logic mac_jam_frame,
	input wire logic serial_tx_data,
	input wire logic hdlc_rx_data,
	input wire logic hdlc_clk_enable
);
	// ----------------------------------------
	// Teardown and SDRAM access
	// ----------------------------------------
	// HDLC clocks stopped means the idle lines show ones
	property p_idle; @(posedge pclk) disable iff (!presetn)
		!hdlc_clk_enable |-> serial_tx_data && hdlc_rx_data; endproperty
	a_idle: assert property (p_idle) else $error("idle lines not one");
	// A done pulse only while the acknowledged access stands
	property p_done; @(posedge pclk) disable iff (!presetn)
		|xfer_done |-> sdram_req && sdram_ack && $onehot(xfer_done); endproperty
	a_done: assert property (p_done) else $error("done without ack");
	// Request held steady until it is answered
	property p_hold; @(posedge pclk) disable iff (!presetn)
		sdram_req && !sdram_ack |=> sdram_req && $stable(sdram_slot) && $stable(sdram_we);
	endproperty
	a_hold: assert property (p_hold) else $error("request changed early");
	property p_end; @(posedge pclk) disable iff (!presetn)
		sdram_req && sdram_ack |=> !sdram_req; endproperty
	a_end: assert property (p_end) else $error("request not released");
	// Direction follows the requester
	property p_wr; @(posedge pclk) disable iff (!presetn)
		xfer_done[0] || xfer_done[2] |-> sdram_we; endproperty
	a_wr: assert property (p_wr) else $error("write not flagged");
	property p_rd; @(posedge pclk) disable iff (!presetn)
		xfer_done[1] || xfer_done[3] |-> !sdram_we; endproperty
	a_rd: assert property (p_rd) else $error("read flagged write");
	property p_excl; @(posedge pclk) disable iff (!presetn)
		(xfer_done & xfer_refused) == 4'h0; endproperty
	a_excl: assert property (p_excl) else $error("done and refused");
	// ----------------------------------------
	// Flow control pulses
	// ----------------------------------------
	property p_pause; @(posedge pclk) disable iff (!presetn)
		mac_pause_send |=> !mac_pause_send; endproperty
	a_pause: assert property (p_pause) else $error("pause longer than one");
	property p_jam; @(posedge pclk) disable iff (!presetn)
		mac_jam_frame |-> $past(mac_rx_frame_start); endproperty
	a_jam: assert property (p_jam) else $error("jam without new frame");
endmodule
bind cqf_top cqf_chk u_chk (.pclk(pclk), .presetn(presetn), .xfer_done(xfer_done),
	.xfer_refused(xfer_refused), .sdram_req(sdram_req), .sdram_we(sdram_we),
	.sdram_slot(sdram_slot), .sdram_ack(sdram_ack), .mac_rx_frame_start(mac_rx_frame_start),
	.mac_pause_send(mac_pause_send), .mac_jam_frame(mac_jam_frame),
	.serial_tx_data(serial_tx_data), .hdlc_rx_data(hdlc_rx_data),
	.hdlc_clk_enable(hdlc_clk_enable));

// File: verilog/cqf_defs.svh
// Register map, field positions, reset values and sizes of the connection queue block
`ifndef CQF_DEFS_SVH
`define CQF_DEFS_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define CQF_CTRL_OFS 12'h000
`define CQF_TXQ_SIZE_OFS 12'h004
`define CQF_RXQ_SIZE_OFS 12'h008
`define CQF_TX_THR_OFS 12'h00C
`define CQF_RX_THR_OFS 12'h010
`define CQF_TX_IE_OFS 12'h014
`define CQF_RX_IE_OFS 12'h018
`define CQF_TX_STAT_OFS 12'h01C
`define CQF_RX_STAT_OFS 12'h020
`define CQF_GLB_IE_OFS 12'h024
`define CQF_GLB_IS_OFS 12'h028
`define CQF_OCC_OFS 12'h02C

// ------------------------------------------------------------
// Control register bits
// ------------------------------------------------------------
`define CQF_CTRL_CONN 0
`define CQF_CTRL_QPR 1
`define CQF_CTRL_AUTO 2
`define CQF_CTRL_JAM 3
`define CQF_CTRL_FCE 4
`define CQF_CTRL_PAUSE 5
`define CQF_CTRL_FDX 6
`define CQF_CTRL_RST 7'h04

// ------------------------------------------------------------
// Status and enable bits, threshold field, sizes
// ------------------------------------------------------------
`define CQF_ST_HIGH 0
`define CQF_ST_LOW 1
`define CQF_ST_OVFL 2
`define CQF_THR_LOW_LSB 16
`define CQF_OCC_RX_LSB 16
`define CQF_QSIZE_W 9
`define CQF_QSIZE_RST 9'h001
`define CQF_THR_RST 9'h000
`define CQF_BLOCK_SHIFT 5
`define CQF_SLOT_W 13
`define CQF_CNT_W 14
`define CQF_SLOT_BYTES 2048

`endif

// File: verilog/cqf_pkg.sv
// Types shared by the connection queue block
package cqf_pkg;

	// Arbiter sequencing
	typedef enum logic [0:0] {
		CQF_ARB_IDLE,
		CQF_ARB_ACCESS
	} cqf_arb_e;

	// Requester index: 0 MAC rx write, 1 HDLC rx read, 2 HDLC tx write, 3 MAC tx read
	typedef logic [1:0] cqf_req_t;

endpackage

// File: verilog/cqf_top.sv
// Connection queue manager: queue pointers, SDRAM arbiter, watermarks and flow control
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
`include "cqf_defs.svh"

module cqf_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [3:0] xfer_req,
	output logic [3:0] xfer_done,
	output logic [3:0] xfer_refused,
	output logic sdram_req,
	output logic sdram_we,
	output logic [`CQF_SLOT_W-1:0] sdram_slot,
	input wire logic sdram_ack,
	input wire logic mac_rx_frame_start,
	input wire logic mac_rx_frame_done,
	output logic mac_flow_ctrl_enable,
	output logic mac_pause_send,
	output logic mac_jam_frame,
	input wire logic hdlc_tx_data,
	output logic serial_tx_data,
	input wire logic serial_rx_pin,
	output logic hdlc_rx_data,
	output logic hdlc_clk_enable,
	output logic queue_irq
);

	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	logic [6:0] ctrl_q;
	logic [`CQF_QSIZE_W-1:0] txq_size_q, rxq_size_q;
	logic [`CQF_QSIZE_W-1:0] tx_high_q, tx_low_q, rx_high_q, rx_low_q;
	logic [1:0] tx_ie_q, rx_ie_q, glb_ie_q;
	logic [1:0] tx_stat_q;
	logic [2:0] rx_stat_q;
	logic [31:0] prdata_q;

	// ------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------
	wire setup_rd = psel & ~penable & ~pwrite;
	wire acc = psel & penable;
	wire wr_en = acc & pwrite;
	wire rd_done = acc & ~pwrite;
	wire hit_ctrl = paddr == `CQF_CTRL_OFS;
	wire hit_txs = paddr == `CQF_TXQ_SIZE_OFS;
	wire hit_rxs = paddr == `CQF_RXQ_SIZE_OFS;
	wire hit_txt = paddr == `CQF_TX_THR_OFS;
	wire hit_rxt = paddr == `CQF_RX_THR_OFS;
	wire hit_txie = paddr == `CQF_TX_IE_OFS;
	wire hit_rxie = paddr == `CQF_RX_IE_OFS;
	wire hit_txst = paddr == `CQF_TX_STAT_OFS;
	wire hit_rxst = paddr == `CQF_RX_STAT_OFS;
	wire hit_gie = paddr == `CQF_GLB_IE_OFS;
	wire hit_gis = paddr == `CQF_GLB_IS_OFS;
	wire hit_occ = paddr == `CQF_OCC_OFS;
	wire hit_any = hit_ctrl | hit_txs | hit_rxs | hit_txt | hit_rxt | hit_txie | hit_rxie
		| hit_txst | hit_rxst | hit_gie | hit_gis | hit_occ;

	// Zero-wait slave; unmapped addresses answer with an error
	assign pready = 1'b1;
	assign pslverr = acc & ~hit_any;
	assign prdata = prdata_q;

	// ------------------------------------------------------------
	// Control fields
	// ------------------------------------------------------------
	wire conn_en = ctrl_q[`CQF_CTRL_CONN];
	wire auto_flow_enable = ctrl_q[`CQF_CTRL_AUTO];
	wire jam_request = ctrl_q[`CQF_CTRL_JAM];
	wire sw_fce = ctrl_q[`CQF_CTRL_FCE];
	wire pause_send_trigger = ctrl_q[`CQF_CTRL_PAUSE];
	wire full_duplex = ctrl_q[`CQF_CTRL_FDX];
	wire flush = ctrl_q[`CQF_CTRL_QPR] | ~conn_en;

	// ------------------------------------------------------------
	// Queue pointers and occupancy
	// ------------------------------------------------------------
	logic [`CQF_SLOT_W-1:0] rx_wr_q, rx_rd_q, tx_wr_q, tx_rd_q;
	logic [`CQF_CNT_W-1:0] rx_cnt_q, tx_cnt_q;
	logic rx_above, rx_full, rx_high_evt, rx_low_evt;
	logic tx_above, tx_full, tx_high_evt, tx_low_evt;

	wire [`CQF_CNT_W-1:0] rx_cap = {rxq_size_q, 5'b0_0000};
	wire [`CQF_CNT_W-1:0] tx_cap = {txq_size_q, 5'b0_0000};
	// transmit region follows receive region, overlap goes unchecked
	wire [`CQF_SLOT_W-1:0] tx_base = rx_cap[`CQF_SLOT_W-1:0];

	// same watermark logic for both queues
	cqf_wmark u_rx_wm (
		.pclk(pclk),
		.presetn(presetn),
		.restart(flush),
		.occ(rx_cnt_q),
		.size(rxq_size_q),
		.high_thr(rx_high_q),
		.low_thr(rx_low_q),
		.above_high(rx_above),
		.full(rx_full),
		.high_evt(rx_high_evt),
		.low_evt(rx_low_evt)
	);

	cqf_wmark u_tx_wm (
		.pclk(pclk),
		.presetn(presetn),
		.restart(flush),
		.occ(tx_cnt_q),
		.size(txq_size_q),
		.high_thr(tx_high_q),
		.low_thr(tx_low_q),
		.above_high(tx_above),
		.full(tx_full),
		.high_evt(tx_high_evt),
		.low_evt(tx_low_evt)
	);

	// ------------------------------------------------------------
	// SDRAM arbiter
	// ------------------------------------------------------------
	cqf_pkg::cqf_arb_e arb_q;
	cqf_pkg::cqf_req_t rr_q, gnt_q, pick;
	logic pick_valid;
	logic [3:0] room;

	// rx queue fed by MAC, drained by HDLC; tx queue the reverse
	assign room = {tx_cnt_q != '0, ~tx_full, rx_cnt_q != '0, ~rx_full};

	always_comb begin
		cqf_pkg::cqf_req_t idx;
		idx = rr_q;
		pick = rr_q;
		pick_valid = 1'b0;
		for (int i = 0; i < 4; i++) begin
			idx = rr_q + i[1:0];
			if (!pick_valid && xfer_req[idx]) begin
				pick = idx;
				pick_valid = 1'b1;
			end
		end
	end

	wire idle = arb_q == cqf_pkg::CQF_ARB_IDLE;
	wire start_ok = idle & pick_valid & room[pick] & conn_en & ~flush;
	// refused while full, disconnected or empty
	wire start_bad = idle & pick_valid & ~(room[pick] & conn_en & ~flush);
	wire fin = (arb_q == cqf_pkg::CQF_ARB_ACCESS) & sdram_ack;

	assign xfer_done = fin ? (4'b0001 << gnt_q) : 4'b0000;
	assign xfer_refused = start_bad ? (4'b0001 << pick) : 4'b0000;

	// Slot address of the chosen request
	logic [`CQF_SLOT_W-1:0] pick_slot;
	always_comb begin
		case (pick)
			2'd0: pick_slot = rx_wr_q;
			2'd1: pick_slot = rx_rd_q;
			2'd2: pick_slot = tx_base + tx_wr_q;
			default: pick_slot = tx_base + tx_rd_q;
		endcase
	end

	// One SDRAM access at a time, held until acknowledged
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			arb_q <= cqf_pkg::CQF_ARB_IDLE;
			rr_q <= 2'd0;
			gnt_q <= 2'd0;
			sdram_req <= 1'b0;
			sdram_we <= 1'b0;
			sdram_slot <= '0;
		end else begin
			case (arb_q)
				cqf_pkg::CQF_ARB_IDLE: begin
					if (start_ok) begin
						arb_q <= cqf_pkg::CQF_ARB_ACCESS;
						gnt_q <= pick;
						sdram_req <= 1'b1;
						sdram_we <= ~pick[0];
						sdram_slot <= pick_slot;
					end
				end
				cqf_pkg::CQF_ARB_ACCESS: begin
					if (sdram_ack) begin
						arb_q <= cqf_pkg::CQF_ARB_IDLE;
						rr_q <= gnt_q + 2'd1;
						sdram_req <= 1'b0;
					end
				end
				default: arb_q <= cqf_pkg::CQF_ARB_IDLE;
			endcase
		end
	end

	// Pointer wrap at region end
	function automatic logic [`CQF_SLOT_W-1:0] nxt(input logic [`CQF_SLOT_W-1:0] p,
		input logic [`CQF_CNT_W-1:0] cap);
		logic [`CQF_CNT_W-1:0] s;
		s = {1'b0, p} + 14'h0001;
		nxt = (s >= cap) ? '0 : s[`CQF_SLOT_W-1:0];
	endfunction

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_wr_q <= '0;
			rx_rd_q <= '0;
			tx_wr_q <= '0;
			tx_rd_q <= '0;
			rx_cnt_q <= '0;
			tx_cnt_q <= '0;
		end else if (flush) begin
			rx_wr_q <= '0;
			rx_rd_q <= '0;
			tx_wr_q <= '0;
			tx_rd_q <= '0;
			rx_cnt_q <= '0;
			tx_cnt_q <= '0;
		end else if (fin) begin
			case (gnt_q)
				2'd0: begin
					rx_wr_q <= nxt(rx_wr_q, rx_cap);
					rx_cnt_q <= rx_cnt_q + 14'h0001;
				end
				2'd1: begin
					rx_rd_q <= nxt(rx_rd_q, rx_cap);
					rx_cnt_q <= rx_cnt_q - 14'h0001;
				end
				2'd2: begin
					tx_wr_q <= nxt(tx_wr_q, tx_cap);
					tx_cnt_q <= tx_cnt_q + 14'h0001;
				end
				default: begin
					tx_rd_q <= nxt(tx_rd_q, tx_cap);
					tx_cnt_q <= tx_cnt_q - 14'h0001;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Flow control
	// ------------------------------------------------------------
	// only the receive high mark steers automatic backpressure
	// full duplex: pause per completed frame while above
	wire auto_pause = auto_flow_enable & full_duplex & mac_rx_frame_done & rx_above;
	// half duplex: jam frames starting while above
	wire auto_jam = auto_flow_enable & ~full_duplex & mac_rx_frame_start & rx_above;
	wire man_jam = ~auto_flow_enable & jam_request & mac_rx_frame_start;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mac_flow_ctrl_enable <= 1'b0;
			mac_pause_send <= 1'b0;
			mac_jam_frame <= 1'b0;
		end else begin
			mac_flow_ctrl_enable <= auto_flow_enable | sw_fce;
			mac_pause_send <= auto_pause | (~auto_flow_enable & pause_send_trigger);
			mac_jam_frame <= auto_jam | man_jam;
		end
	end

	// ------------------------------------------------------------
	// Serial side gating
	// ------------------------------------------------------------
	logic rx_pin_m, rx_pin_s;

	// Pin is asynchronous to pclk
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_pin_m <= 1'b1;
			rx_pin_s <= 1'b1;
		end else begin
			rx_pin_m <= serial_rx_pin;
			rx_pin_s <= rx_pin_m;
		end
	end

	// idle ones and stopped HDLC clocks while disconnected
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			serial_tx_data <= 1'b1;
			hdlc_rx_data <= 1'b1;
			hdlc_clk_enable <= 1'b0;
		end else begin
			serial_tx_data <= conn_en ? hdlc_tx_data : 1'b1;
			hdlc_rx_data <= conn_en ? rx_pin_s : 1'b1;
			hdlc_clk_enable <= conn_en;
		end
	end

	// ------------------------------------------------------------
	// Register writes and latched status
	// ------------------------------------------------------------
	wire [1:0] glb_is = {|(rx_stat_q[1:0] & rx_ie_q), |(tx_stat_q & tx_ie_q)};
	assign queue_irq = |(glb_is & glb_ie_q);

	// Control: strobe bits self-clear; automatic mode set at reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `CQF_CTRL_RST;
		end else if (wr_en & hit_ctrl) begin
			ctrl_q <= pwdata[6:0];
		end else begin
			ctrl_q[`CQF_CTRL_QPR] <= 1'b0;
			ctrl_q[`CQF_CTRL_PAUSE] <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txq_size_q <= `CQF_QSIZE_RST;
			rxq_size_q <= `CQF_QSIZE_RST;
			tx_high_q <= `CQF_THR_RST;
			tx_low_q <= `CQF_THR_RST;
			rx_high_q <= `CQF_THR_RST;
			rx_low_q <= `CQF_THR_RST;
			tx_ie_q <= 2'h0;
			rx_ie_q <= 2'h0;
			glb_ie_q <= 2'h0;
		end else if (wr_en) begin
			if (hit_txs) txq_size_q <= pwdata[`CQF_QSIZE_W-1:0];
			if (hit_rxs) rxq_size_q <= pwdata[`CQF_QSIZE_W-1:0];
			if (hit_txt) tx_high_q <= pwdata[`CQF_QSIZE_W-1:0];
			if (hit_txt) tx_low_q <= pwdata[`CQF_THR_LOW_LSB +: `CQF_QSIZE_W];
			if (hit_rxt) rx_high_q <= pwdata[`CQF_QSIZE_W-1:0];
			if (hit_rxt) rx_low_q <= pwdata[`CQF_THR_LOW_LSB +: `CQF_QSIZE_W];
			if (hit_txie) tx_ie_q <= pwdata[1:0];
			if (hit_rxie) rx_ie_q <= pwdata[1:0];
			if (hit_gie) glb_ie_q <= pwdata[1:0];
		end
	end

	// events latch; read clears, a same-cycle event wins
	wire [1:0] tx_ev = {tx_low_evt, tx_high_evt};
	wire [2:0] rx_ev = {start_bad & (pick == 2'd0) & conn_en & ~flush, rx_low_evt, rx_high_evt};
	// Only bits already captured for the reader clear, so a late event is not lost
	wire [1:0] tx_clr = (rd_done & hit_txst) ? prdata_q[1:0] : 2'h0;
	wire [2:0] rx_clr = (rd_done & hit_rxst) ? prdata_q[2:0] : 3'h0;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_stat_q <= 2'h0;
			rx_stat_q <= 3'h0;
		end else begin
			tx_stat_q <= (tx_stat_q & ~tx_clr) | tx_ev;
			rx_stat_q <= (rx_stat_q & ~rx_clr) | rx_ev;
		end
	end

	// Read data captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (setup_rd) begin
			prdata_q <= 32'h0000_0000;
			if (hit_ctrl) prdata_q[6:0] <= ctrl_q;
			if (hit_txs) prdata_q[`CQF_QSIZE_W-1:0] <= txq_size_q;
			if (hit_rxs) prdata_q[`CQF_QSIZE_W-1:0] <= rxq_size_q;
			if (hit_txt) prdata_q <= {7'h00, tx_low_q, 7'h00, tx_high_q};
			if (hit_rxt) prdata_q <= {7'h00, rx_low_q, 7'h00, rx_high_q};
			if (hit_txie) prdata_q[1:0] <= tx_ie_q;
			if (hit_rxie) prdata_q[1:0] <= rx_ie_q;
			if (hit_txst) prdata_q[1:0] <= tx_stat_q;
			if (hit_rxst) prdata_q[2:0] <= rx_stat_q;
			if (hit_gie) prdata_q[1:0] <= glb_ie_q;
			if (hit_gis) prdata_q[1:0] <= glb_is;
			if (hit_occ) prdata_q <= {2'b00, rx_cnt_q, 2'b00, tx_cnt_q};
		end
	end

endmodule

// File: verilog/cqf_wmark.sv
// Watermark tracker for one packet queue
`timescale 1ns/100ps
`include "cqf_defs.svh"

module cqf_wmark (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic restart,
	input wire logic [`CQF_CNT_W-1:0] occ,
	input wire logic [`CQF_QSIZE_W-1:0] size,
	input wire logic [`CQF_QSIZE_W-1:0] high_thr,
	input wire logic [`CQF_QSIZE_W-1:0] low_thr,
	output logic above_high,
	output logic full,
	output logic high_evt,
	output logic low_evt
);

	logic above_high_q;
	logic above_low_q;
	logic above_low;

	// Thresholds and size count whole blocks of 32 slots
	assign above_high = occ > {high_thr, 5'b0_0000};
	assign above_low = occ > {low_thr, 5'b0_0000};
	assign full = occ >= {size, 5'b0_0000};
	// Rising past high only; low fires on a crossing either way
	assign high_evt = above_high & ~above_high_q;
	assign low_evt = above_low ^ above_low_q;

	// Restart makes an empty queue the new reference
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			above_high_q <= 1'b0;
			above_low_q <= 1'b0;
		end else if (restart) begin
			above_high_q <= 1'b0;
			above_low_q <= 1'b0;
		end else begin
			above_high_q <= above_high;
			above_low_q <= above_low;
		end
	end

endmodule
